// *** include/timer16_defines.svh ***
// Purpose: offsets, field positions, reset values and TOP constants of the 16-bit timer
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   definitions only
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ============================================================
// register indices
`define IDX_CTRL_A   8'h2f
`define IDX_CTRL_B   8'h2e
`define IDX_STATUS   8'h2b
`define IDX_CNT      8'h2c
`define IDX_CMP_A    8'h2a
`define IDX_CMP_B    8'h28
`define IDX_CAPT     8'h26

// ============================================================
// field positions
`define ACT_A_HI     7
`define ACT_A_LO     6
`define ACT_B_HI     5
`define ACT_B_LO     4
`define WGM_LOW_HI   1
`define WGM_LOW_LO   0
`define WGM_HIGH_HI  4
`define WGM_HIGH_LO  3
`define ST_OVF       0
`define ST_DOWN      1

// ============================================================
// reset values and writable masks
`define CTRL_A_RST   8'h00
`define CTRL_B_RST   8'h00
`define CTRL_A_MASK  8'hf3
`define CTRL_B_MASK  8'h18
`define CNT_RST      16'h0000

// ============================================================
// fixed TOP values
`define TOP_MAX      16'hffff
`define TOP_8BIT     16'h00ff
`define TOP_9BIT     16'h01ff
`define TOP_10BIT    16'h03ff

`endif

// *** include/timer16_pkg.sv ***
// Purpose: types shared by the timer waveform control files
// Assumes: nothing beyond the defines header
// Notes:   mode classes drive compare-output decoding
package timer16_pkg;
    typedef enum logic [2:0] {
        CLS_NORMAL = 3'h0,
        CLS_CTC    = 3'h1,
        CLS_FAST   = 3'h3,
        CLS_PC     = 3'h2,
        CLS_PFC    = 3'h6
    } mode_class_t;

    typedef enum logic {
        DIR_UP   = 1'h0,
        DIR_DOWN = 1'h1
    } count_dir_t;
endpackage

// *** rtl/compare_output_unit.sv ***
// Purpose: one compare channel: output action decode and pin override
// Assumes: match, wrap and counting_up are same-cycle timer events
// Notes:   outputs are registered
`timescale 1ns/1ps
module compare_output_unit #(
    parameter bit IS_CHAN_A = 1'b1
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [1:0]                action,
    input  timer16_pkg::mode_class_t       mode_class,
    input  wire logic                      top_bit,
    input  wire logic                      match,
    input  wire logic                      wrap,
    input  wire logic                      counting_up,
    input  wire logic                      cmp_at_top,
    output logic                           oc,
    output logic                           connect
);
    import timer16_pkg::*;

    logic oc_r;
    logic oc_nxt;
    logic conn_r;
    logic conn_nxt;

    // ============================================================
    // action decode
    always_comb begin
        oc_nxt   = oc_r;
        conn_nxt = (action != 2'h0);
        case (mode_class)
            CLS_FAST: begin
                if (action == 2'h1 && !top_bit) begin
                    conn_nxt = 1'b0;
                end
                if (action[1]) begin
                    // match at TOP is dropped, BOTTOM still acts
                    if (match && !cmp_at_top) begin
                        oc_nxt = action[0];
                    end else if (wrap) begin
                        oc_nxt = ~action[0];
                    end
                end else if (action == 2'h1 && top_bit && IS_CHAN_A && match) begin
                    oc_nxt = ~oc_r;
                end
            end
            CLS_PC, CLS_PFC: begin
                if (action == 2'h1 && !top_bit) begin
                    conn_nxt = 1'b0;
                end
                if (action[1] && match) begin
                    oc_nxt = counting_up ? action[0] : ~action[0];
                end else if (action == 2'h1 && top_bit && IS_CHAN_A && match) begin
                    oc_nxt = ~oc_r;
                end
            end
            default: begin
                if (match && action == 2'h1) begin
                    oc_nxt = ~oc_r;
                end else if (match && action[1]) begin
                    oc_nxt = action[0];
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oc_r   <= 1'b0;
            conn_r <= 1'b0;
        end else begin
            oc_r   <= oc_nxt;
            conn_r <= conn_nxt;
        end
    end

    assign oc      = oc_r;
    assign connect = conn_r;

    // ============================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    toggle_on_match_a: assert property (
        (mode_class == CLS_NORMAL && action == 2'h1 && match) |=> oc_r != $past(oc_r))
        else $error("toggle on match missed");
    dual_up_clear_a: assert property (
        ((mode_class == CLS_PC || mode_class == CLS_PFC) && action == 2'h2 && match
         && counting_up) |=> !oc_r)
        else $error("dual slope clear on upcount missed");
    fast_bottom_set_a: assert property (
        (mode_class == CLS_FAST && action == 2'h2 && wrap && !(match && !cmp_at_top))
        |=> oc_r)
        else $error("fast pwm set at bottom missed");
endmodule

// *** rtl/timer16_waveform_mode_control.sv ***
// Purpose: 16-bit timer counter with mode decode and two compare outputs, APB slave
// Assumes: timer_tick is a one-cycle enable from the prescaler on clk_sys
// Notes:   compare registers are double buffered in PWM modes
//
// What this block does
// - nonzero output-action field makes the compare output override its pin, except 01 in PWM modes with top mode bit 0
// - output-action decoding depends on mode class: non-PWM, fast, dual-slope
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clear on match set at bottom, 11 the inverse
// - fast PWM 01: port normal if top mode bit 0, else toggle A only
// - dual-slope 01: disconnected if top mode bit 0, else toggle A only
// - dual-slope: 10 clears upcounting, sets downcounting; 11 inverse
// - fast PWM: compare equal TOP with high action bit ignores match
// - low mode bits plus high pair form the four-bit mode number
// - mode 0: TOP 0xffff, immediate compare load, overflow at MAX
// - phase correct modes: fixed or register TOP, reload at TOP, overflow at BOTTOM
// - clear-on-match modes 4 and 12: immediate load, overflow at MAX
// - fast PWM modes: fixed or register TOP, reload and overflow at TOP
// - modes 8 and 9: reload and overflow at BOTTOM
// - high mode bits live at bits 4:3 of the second control register
// - dual-slope counter turns at TOP: the tick at TOP already counts down
// - phase and frequency correct overflow coincides with the bottom reload
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "timer16_defines.svh"
module timer16_waveform_mode_control (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [9:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                timer_tick,
    output logic                     compare_out_a,
    output logic                     compare_out_b,
    output logic                     out_a_override,
    output logic                     out_b_override,
    output logic                     overflow_flag
);
    import timer16_pkg::*;

    logic [7:0]  ctrl_a_r, ctrl_a_nxt;
    logic [7:0]  ctrl_b_r, ctrl_b_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] cmp_a_r, cmp_a_nxt;
    logic [15:0] cmp_b_r, cmp_b_nxt;
    logic [15:0] buf_a_r, buf_a_nxt;
    logic [15:0] buf_b_r, buf_b_nxt;
    logic [15:0] capt_r, capt_nxt;
    count_dir_t  dir_r, dir_nxt;
    logic        ovf_r, ovf_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;

    logic [3:0]  mode;
    mode_class_t cls;
    logic [15:0] top;
    logic        dual;
    logic        wr_en;
    logic [7:0]  idx;
    logic        at_top_evt;
    logic        at_bot_evt;
    logic        reload;
    logic        ovf_evt;
    logic        cnt_wr;

    // ============================================================
    // mode decode
    function automatic mode_class_t class_of(input logic [3:0] m);
        case (m)
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb:       class_of = CLS_PC;
            4'h4, 4'hc:                         class_of = CLS_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf:       class_of = CLS_FAST;
            4'h8, 4'h9:                         class_of = CLS_PFC;
            default:                            class_of = CLS_NORMAL;
        endcase
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0]  m,
                                           input logic [15:0] ca,
                                           input logic [15:0] cp);
        case (m)
            4'h1, 4'h5:                         top_of = `TOP_8BIT;
            4'h2, 4'h6:                         top_of = `TOP_9BIT;
            4'h3, 4'h7:                         top_of = `TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf:             top_of = ca;
            4'h8, 4'ha, 4'hc, 4'he:             top_of = cp;
            default:                            top_of = `TOP_MAX;
        endcase
    endfunction

    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == `IDX_CTRL_A) || (i == `IDX_CTRL_B) || (i == `IDX_STATUS)
                 || (i == `IDX_CNT) || (i == `IDX_CMP_A) || (i == `IDX_CMP_B)
                 || (i == `IDX_CAPT);
    endfunction

    assign mode = {ctrl_b_r[`WGM_HIGH_HI:`WGM_HIGH_LO],
                   ctrl_a_r[`WGM_LOW_HI:`WGM_LOW_LO]};
    assign cls  = class_of(mode);
    assign top  = top_of(mode, cmp_a_r, capt_r);
    assign dual = (cls == CLS_PC) || (cls == CLS_PFC);

    // ============================================================
    // timer events
    assign idx        = paddr[9:2];
    assign wr_en      = psel && penable && pready_r && pwrite;
    assign cnt_wr     = wr_en && idx == `IDX_CNT;
    assign at_top_evt = timer_tick && cnt_r == top;
    assign at_bot_evt = timer_tick && cnt_r == 16'h0000 && dir_r == DIR_DOWN;

    always_comb begin
        reload  = 1'b0;
        ovf_evt = 1'b0;
        case (cls)
            CLS_FAST: begin
                reload  = at_top_evt;
                ovf_evt = at_top_evt;
            end
            CLS_PC: begin
                reload  = at_top_evt;
                ovf_evt = at_bot_evt;
            end
            CLS_PFC: begin
                reload  = at_bot_evt;
                ovf_evt = at_bot_evt;
            end
            default: begin
                ovf_evt = timer_tick && cnt_r == `TOP_MAX;
            end
        endcase
    end

    // ============================================================
    // counter and direction
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (cnt_wr) begin
            cnt_nxt = pwdata[15:0];
        end else if (timer_tick) begin
            if (!dual) begin
                dir_nxt = DIR_UP;
                cnt_nxt = (cnt_r == top) ? 16'h0000 : cnt_r + 16'h0001;
            end else if (dir_r == DIR_UP) begin
                // the tick at top turns the direction and already counts down
                if (cnt_r >= top) begin
                    dir_nxt = DIR_DOWN;
                    cnt_nxt = (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end else if (cnt_r == 16'h0000) begin
                dir_nxt = DIR_UP;
                cnt_nxt = (top == 16'h0000) ? 16'h0000 : 16'h0001;
            end else begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end
    end

    // ============================================================
    // register file and APB
    always_comb begin
        ctrl_a_nxt  = ctrl_a_r;
        ctrl_b_nxt  = ctrl_b_r;
        buf_a_nxt   = buf_a_r;
        buf_b_nxt   = buf_b_r;
        cmp_a_nxt   = reload ? buf_a_r : cmp_a_r;
        cmp_b_nxt   = reload ? buf_b_r : cmp_b_r;
        capt_nxt    = capt_r;
        // set wins over a simultaneous write-one clear
        ovf_nxt     = ovf_evt || ovf_r;
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = psel && penable && !pready_r && !is_mapped(idx);
        prdata_nxt  = prdata_r;
        if (psel && penable && !pready_r) begin
            case (idx)
                `IDX_CTRL_A: prdata_nxt = {24'h000000, ctrl_a_r};
                `IDX_CTRL_B: prdata_nxt = {24'h000000, ctrl_b_r};
                `IDX_STATUS: prdata_nxt = {30'h00000000, dir_r == DIR_DOWN, ovf_r};
                `IDX_CNT:    prdata_nxt = {16'h0000, cnt_r};
                `IDX_CMP_A:  prdata_nxt = {16'h0000, buf_a_r};
                `IDX_CMP_B:  prdata_nxt = {16'h0000, buf_b_r};
                `IDX_CAPT:   prdata_nxt = {16'h0000, capt_r};
                default:     prdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_en) begin
            case (idx)
                `IDX_CTRL_A: ctrl_a_nxt = pwdata[7:0] & `CTRL_A_MASK;
                `IDX_CTRL_B: ctrl_b_nxt = pwdata[7:0] & `CTRL_B_MASK;
                `IDX_STATUS: ovf_nxt = ovf_evt || (ovf_r && !pwdata[`ST_OVF]);
                `IDX_CMP_A: begin
                    buf_a_nxt = pwdata[15:0];
                    if (!(cls == CLS_FAST || dual)) begin
                        cmp_a_nxt = pwdata[15:0];
                    end
                end
                `IDX_CMP_B: begin
                    buf_b_nxt = pwdata[15:0];
                    if (!(cls == CLS_FAST || dual)) begin
                        cmp_b_nxt = pwdata[15:0];
                    end
                end
                `IDX_CAPT:   capt_nxt = pwdata[15:0];
                default:     capt_nxt = capt_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_a_r  <= `CTRL_A_RST;
            ctrl_b_r  <= `CTRL_B_RST;
            cnt_r     <= `CNT_RST;
            cmp_a_r   <= `CNT_RST;
            cmp_b_r   <= `CNT_RST;
            buf_a_r   <= `CNT_RST;
            buf_b_r   <= `CNT_RST;
            capt_r    <= `CNT_RST;
            dir_r     <= DIR_UP;
            ovf_r     <= 1'b0;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_a_r  <= ctrl_a_nxt;
            ctrl_b_r  <= ctrl_b_nxt;
            cnt_r     <= cnt_nxt;
            cmp_a_r   <= cmp_a_nxt;
            cmp_b_r   <= cmp_b_nxt;
            buf_a_r   <= buf_a_nxt;
            buf_b_r   <= buf_b_nxt;
            capt_r    <= capt_nxt;
            dir_r     <= dir_nxt;
            ovf_r     <= ovf_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign overflow_flag = ovf_r;

    // ============================================================
    // compare channels
    compare_output_unit #(.IS_CHAN_A(1'b1)) u_chan_a (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .action      (ctrl_a_r[`ACT_A_HI:`ACT_A_LO]),
        .mode_class  (cls),
        .top_bit     (mode[3]),
        .match       (timer_tick && cnt_r == cmp_a_r),
        .wrap        (cls == CLS_FAST && at_top_evt),
        .counting_up (dir_r == DIR_UP),
        .cmp_at_top  (cmp_a_r == top),
        .oc          (compare_out_a),
        .connect     (out_a_override)
    );

    compare_output_unit #(.IS_CHAN_A(1'b0)) u_chan_b (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .action      (ctrl_a_r[`ACT_B_HI:`ACT_B_LO]),
        .mode_class  (cls),
        .top_bit     (mode[3]),
        .match       (timer_tick && cnt_r == cmp_b_r),
        .wrap        (cls == CLS_FAST && at_top_evt),
        .counting_up (dir_r == DIR_UP),
        .cmp_at_top  (cmp_b_r == top),
        .oc          (compare_out_b),
        .connect     (out_b_override)
    );

    // ============================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence top_reached_s;
        timer_tick && dual && dir_r == DIR_UP && cnt_r == top && top != 16'h0000 && !cnt_wr;
    endsequence

    normal_ovf_max_a: assert property (
        (cls == CLS_NORMAL && timer_tick && cnt_r == 16'hffff && !cnt_wr)
        |=> ovf_r && cnt_r == 16'h0000)
        else $error("normal mode overflow at max missed");
    dual_top_turn_a: assert property (
        top_reached_s |=> dir_r == DIR_DOWN && cnt_r == $past(cnt_r) - 16'h0001)
        else $error("dual slope did not turn after top");
    ctc_clear_a: assert property (
        (cls == CLS_CTC && at_top_evt && !cnt_wr) |=> cnt_r == 16'h0000)
        else $error("clear on match did not clear counter");
    fast_ovf_top_a: assert property (
        (cls == CLS_FAST && at_top_evt && !cnt_wr) |=> ovf_r && cnt_r == 16'h0000
        && cmp_a_r == $past(buf_a_r))
        else $error("fast pwm top events missed");
    pfc_bottom_a: assert property (
        (cls == CLS_PFC && at_bot_evt) |=> ovf_r && cmp_b_r == $past(buf_b_r))
        else $error("bottom reload and overflow not together");
    pc_fixed_top_a: assert property (
        (mode == 4'h1 && timer_tick && dir_r == DIR_UP && cnt_r == 16'h00ff && !cnt_wr)
        |=> dir_r == DIR_DOWN)
        else $error("phase correct 8-bit top wrong");
    chan_override_a: assert property (
        (cls == CLS_NORMAL && ctrl_a_r[7:6] != 2'h0)[*2] |-> out_a_override)
        else $error("channel a override missing");
    reserved_zero_a: assert property (
        (pready_r && idx == `IDX_CTRL_A && !pwrite && psel) |-> prdata_r[3:2] == 2'h0
        && prdata_r[31:8] == 24'h000000)
        else $error("reserved control bits read nonzero");
    apb_answer_a: assert property (
        (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb answer timing wrong");
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the timer waveform control block
// Assumes: APB answer within a bounded wait; timer outputs registered
// Notes:   one integer model per tick; channel B runs A's settings and must match it
`timescale 1ns/1ps
`include "timer16_defines.svh"
module testbench;
    import timer16_pkg::*;
    logic        clk_sys    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [9:0]  paddr      = 10'h000;
    logic [31:0] pwdata     = 32'h0;
    logic        timer_tick = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, compare_out_a, compare_out_b;
    logic        out_a_override, out_b_override, overflow_flag;
    int          err_count  = 0;
    int          n_tests    = 0;
    int          cyc        = 0;
    int          m_cnt, m_dir, m_out, m_ovf, m_cls, m_top, m_cmp, m_act;
    int          m_act_tab[3] = '{1, 3, 2};

    timer16_waveform_mode_control timer16_waveform_mode_control_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
        .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
        .out_a_override(out_a_override), .out_b_override(out_b_override),
        .overflow_flag(overflow_flag)
    );

    always #10 clk_sys = ~clk_sys;

    // ============================================================
    // verdict and hang guard
    task automatic finish_test;
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ============================================================
    // APB master: holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, idx, wd, rd, er);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, idx, 32'h0, rd, er);
        chk(rd, exp);
        chk(er, experr);
    endtask

    // ============================================================
    // one timer step, mirrored in the integer model
    task automatic tick_step;
        int c;
        c = m_cnt;
        @(posedge clk_sys);
        timer_tick <= 1'b1;
        @(posedge clk_sys);
        timer_tick <= 1'b0;
        if (c == m_cmp) begin
            if (m_act == 1) m_out = !m_out;
            else if (m_act >= 2) m_out = (m_cls == 2 && m_dir == 1) ? !(m_act & 1) : (m_act & 1);
        end
        if (m_cls == 2) begin
            if (m_dir == 0 && c == m_top) m_dir = 1;
            else if (m_dir == 1 && c == 0) begin
                // overflow only on the tick at bottom that turns the count upwards
                m_dir = 0;
                m_ovf = 1;
            end
            m_cnt = m_dir ? c - 1 : c + 1;
        end else if (c == m_top) begin
            m_cnt = 0;
            if (m_cls == 1 || c == 32'hffff) m_ovf = 1;
            if (m_cls == 1 && m_act >= 2) m_out = !(m_act & 1);
        end else m_cnt = c + 1;
        repeat (2) @(posedge clk_sys);
        chk(compare_out_a, m_out[0]);
        chk(compare_out_b, m_out[0]);
        chk(overflow_flag, m_ovf[0]);
    endtask

    task automatic set_cnt(input int v);
        wr(`IDX_CNT, v);
        m_cnt = v;
    endtask

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'hccc3));
        {m_cnt, m_dir, m_out, m_ovf, m_cls, m_act} = '0;
        m_top = 32'hffff;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(`IDX_CTRL_A, 32'h0, 1'b0);
        wr(`IDX_CTRL_A, 32'hff);
        rdc(`IDX_CTRL_A, 32'hf3, 1'b0);
        wr(`IDX_CTRL_B, 32'hff);
        rdc(`IDX_CTRL_B, 32'h18, 1'b0);
        rdc(8'h00, 32'h0, 1'b1);
        wr(`IDX_CTRL_B, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`IDX_CTRL_A, {24'h0, i[1:0], 2'(3 - i), 4'h0});
            repeat (2) @(posedge clk_sys);
            chk(out_a_override, i != 0);
            chk(out_b_override, i != 3);
        end
        // normal mode: toggle, set, clear, then overflow at MAX; B mirrors A
        m_cmp = 1 + $urandom % 6;
        wr(`IDX_CMP_A, m_cmp);
        wr(`IDX_CMP_B, m_cmp);
        foreach (m_act_tab[k]) begin
            m_act = m_act_tab[k];
            wr(`IDX_CTRL_A, (m_act << 6) | (m_act << 4));
            set_cnt(0);
            repeat (8) tick_step();
        end
        set_cnt(32'hfffe);
        repeat (3) tick_step();
        rdc(`IDX_STATUS, 32'h1, 1'b0);
        wr(`IDX_STATUS, 32'h1);
        m_ovf = 0;
        // clear-on-match mode 4: wraps at compare A, no overflow below MAX
        wr(`IDX_CTRL_B, 32'h08);
        wr(`IDX_CTRL_A, 32'h50);
        m_act = 1;
        m_top = m_cmp;
        set_cnt(0);
        repeat (16) tick_step();
        // fast PWM, phase correct, then phase and frequency correct, all 8-bit TOP
        m_cmp = 8'h10 + $urandom % 8'hc0;
        wr(`IDX_CMP_A, m_cmp);
        wr(`IDX_CMP_B, m_cmp);
        wr(`IDX_CAPT, 32'hff);
        for (int md = 1; md <= 3; md++) begin
            wr(`IDX_CTRL_B, md == 1 ? 32'h08 : md == 2 ? 32'h00 : 32'h10);
            m_cls = md == 1 ? 1 : 2;
            m_top = 32'hff;
            for (int a = 2; a <= 3; a++) begin
                m_act = a;
                wr(`IDX_CTRL_A, (a << 6) | (a << 4) | (md < 3));
                if (a == 2) set_cnt(0);
                repeat (520) tick_step();
            end
            rdc(`IDX_CNT, m_cnt, 1'b0);
            rdc(`IDX_STATUS, {30'h0, m_dir[0], m_ovf[0]}, 1'b0);
            wr(`IDX_STATUS, 32'h1);
            m_ovf = 0;
        end
        finish_test();
    end
endmodule
